// [verilog/ccr_defines.vh]
// register map, field positions, reset values and constants for the core register block
//
// Contract
// RULE1 - bank bits map registers to RAM banks
// RULE2 - carry from bit7 carry or borrow
// RULE3 - nibble carry across low/high halves
// RULE4 - overflow when signed range exceeded
// RULE5 - bit0 read-only accumulator odd parity
// RULE6 - bits 5 and 1 software user flags
// RULE7 - flag update set per operation class
// RULE8 - set/clear/bit ops change only carry
// RULE9 - accumulator 8-bit, resets to zero
// RULE10 - aux register 8-bit, resets to zero
// RULE11 - two pointers, selected by select bit
// RULE12 - low/high bytes form 16-bit pointer
// RULE13 - push increments pointer before store
// RULE14 - pop reads first, then decrements
// RULE15 - stack pointer resets to seven
// RULE16 - bank locations remain ordinary RAM
// RULE17 - config reads per boot state, variant
// RULE18 - identity register read-only fixed code
// RULE19 - unlock write-only, shares identity address
// RULE20 - power control resets to 10h
// RULE21 - unlock by 55h then AAh, timed
// RULE22 - boot bit set power-on, cleared soft
// RULE23 - explicit status write beats flag updates
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

// register addresses
`define CCR_ADDR_SP      8'h81
`define CCR_ADDR_DPL     8'h82
`define CCR_ADDR_DPH     8'h83
`define CCR_ADDR_PWR     8'h87
`define CCR_ADDR_ID      8'hA1
`define CCR_ADDR_XAUX    8'hA2
`define CCR_ADDR_CFG     8'hB1
`define CCR_ADDR_PSW     8'hD0
`define CCR_ADDR_ACC     8'hE0
`define CCR_ADDR_AUX     8'hF0

// reset values
`define CCR_RST_SP       8'h07
`define CCR_RST_ZERO     8'h00
`define CCR_RST_PWR      8'h10
`define CCR_RST_PTR      16'h0000

// status word bit positions
`define CCR_PSW_CY       7
`define CCR_PSW_AC       6
`define CCR_PSW_F0       5
`define CCR_PSW_RS1      4
`define CCR_PSW_RS0      3
`define CCR_PSW_OV       2
`define CCR_PSW_F1       1
`define CCR_PSW_P        0

// config register fields
`define CCR_CFG_BOOT     5
`define CCR_CFG_SWRST    4
`define CCR_CFG_TOP_BIG  2'b10
`define CCR_CFG_TOP_SML  2'b11
`define CCR_CFG_LOW_MSK  8'h0F
`define CCR_XAUX_SEL     0

// unlock sequence codes
`define CCR_UNLOCK_A     8'h55
`define CCR_UNLOCK_B     8'hAA

// protected window, in nanoseconds, and clock period
`define CCR_SAFE_NS      575
`define CCR_CLK_NS       25

// flag operation codes
`define CCR_OP_NONE      4'h0
`define CCR_OP_ADD       4'h1
`define CCR_OP_ADDC      4'h2
`define CCR_OP_SUBB      4'h3
`define CCR_OP_MULDIV    4'h4
`define CCR_OP_CYONLY    4'h5
`define CCR_OP_SETC      4'h6
`define CCR_OP_CLRC      4'h7

`endif

// [verilog/ccr_flag_unit.v]
// combinational carry, nibble carry and overflow generator
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.vh"

module ccr_flag_unit (
  // operands
  input  wire [7:0] opa_i,
  input  wire [7:0] opb_i,
  input  wire       cin_i,
  input  wire       sub_i,
  // results
  output reg  [7:0] sum_o,
  output reg        cy_o,
  output reg        ac_o,
  output reg        ov_o
);

  reg [8:0] full_w; // wide sum
  reg [4:0] nib_w;  // low nibble sum

  // add or subtract with borrow
  always @* begin
    full_w = 9'h000;
    nib_w  = 5'h00;
    if (sub_i) begin
      full_w = {1'b0, opa_i} - {1'b0, opb_i} - {8'h00, cin_i};
      nib_w  = {1'b0, opa_i[3:0]} - {1'b0, opb_i[3:0]} - {4'h0, cin_i};
    end else begin
      full_w = {1'b0, opa_i} + {1'b0, opb_i} + {8'h00, cin_i};
      nib_w  = {1'b0, opa_i[3:0]} + {1'b0, opb_i[3:0]} + {4'h0, cin_i};
    end
    sum_o = full_w[7:0];
    // RULE2 carry out of top bit
    cy_o  = full_w[8];
    // RULE3 nibble boundary carry
    ac_o  = nib_w[4];
    // RULE4 signed range overflow
    if (sub_i)
      ov_o = (opa_i[7] != opb_i[7]) && (full_w[7] != opa_i[7]);
    else
      ov_o = (opa_i[7] == opb_i[7]) && (full_w[7] != opa_i[7]);
  end

endmodule
`default_nettype wire

// [verilog/ccr_pointer_bank.v]
// two physical 16-bit data pointers with a select
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.vh"

module ccr_pointer_bank (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        reset_n_i,
  // control
  input  wire        sel_i,
  input  wire        wr_lo_i,
  input  wire        wr_hi_i,
  input  wire [7:0]  wdata_i,
  // selected pointer
  output wire [15:0] ptr_o
);

  reg [15:0] ptr0_q; // pointer zero
  reg [15:0] ptr1_q; // pointer one

  // RULE11 selected pointer takes byte writes
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr0_q <= `CCR_RST_PTR;
      ptr1_q <= `CCR_RST_PTR;
    end else begin
      if (wr_lo_i && !sel_i) ptr0_q[7:0]  <= wdata_i;
      if (wr_hi_i && !sel_i) ptr0_q[15:8] <= wdata_i;
      if (wr_lo_i && sel_i)  ptr1_q[7:0]  <= wdata_i;
      if (wr_hi_i && sel_i)  ptr1_q[15:8] <= wdata_i;
    end
  end

  // RULE11 current pointer view
  assign ptr_o = sel_i ? ptr1_q : ptr0_q;

endmodule
`default_nettype wire

// [verilog/ccr_core_regs.v]
// core special-function registers: accumulator, aux, status, pointers, stack, config
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.vh"

module ccr_core_regs #(
  parameter       BIG_VARIANT = 1,     // 1 larger device, 0 smaller
  parameter [7:0] ID_BIG      = 8'hC5, // arbitrary identity value
  parameter [7:0] ID_SMALL    = 8'hC4  // arbitrary identity value
) (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        reset_n_i,
  // register port
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  // arithmetic flag request
  input  wire [3:0]  flag_op_i,
  input  wire [7:0]  opb_i,
  input  wire        cy_value_i,
  input  wire        md_ov_i,
  input  wire        acc_wr_i,
  input  wire [7:0]  acc_wdata_i,
  // stack requests
  input  wire        push_i,
  input  wire        pop_i,
  // views
  output reg  [7:0]  acc_o,
  output reg  [7:0]  psw_o,
  output reg  [7:0]  sp_o,
  output reg  [15:0] data_pointer_word_o,
  output reg  [4:0]  bank_base_o,
  output reg  [7:0]  stack_addr_o,
  output reg         safe_open_o,
  output reg         sw_reset_o
);

  // protected window length in clocks, rounded down
  localparam integer SAFE_CYC = `CCR_SAFE_NS / `CCR_CLK_NS;

  // one-hot unlock states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_HALF = 3'b010;
  localparam [2:0] ST_OPEN = 3'b100;

  reg  [7:0]  acc_q;        // accumulator
  reg  [7:0]  aux_q;        // multiply/divide aux
  reg  [7:0]  psw_q;        // status word without parity
  reg  [7:0]  sp_q;         // stack pointer
  reg  [7:0]  pwr_q;        // power control
  reg  [7:0]  xaux_q;       // external bus aux
  reg  [3:0]  cfg_low_q;    // config low bits
  reg         boot_q;       // boot state flag
  reg  [7:0]  unlock_q;     // last unlock write
  reg  [2:0]  st_q;         // unlock state
  reg  [4:0]  safe_cnt_q;   // window counter
  reg         swr_q;        // soft reset pending
  reg  [7:0]  rdata_d;      // read mux
  reg  [7:0]  psw_d;        // next status
  wire [7:0]  sum_w;        // adder result
  wire        cy_w;         // adder carry
  wire        ac_w;         // adder nibble carry
  wire        ov_w;         // adder overflow
  wire [15:0] ptr_w;        // selected pointer
  wire        parity_w;     // accumulator parity
  wire [7:0]  cfg_w;        // config read value
  wire        is_sub_w;     // subtract op
  wire        cin_w;        // adder carry in

  // adder operand setup
  assign is_sub_w = (flag_op_i == `CCR_OP_SUBB);
  assign cin_w    = (flag_op_i == `CCR_OP_ADDC || is_sub_w) ? psw_q[`CCR_PSW_CY] : 1'b0;

  // arithmetic flag generator
  ccr_flag_unit u_flags (
    .opa_i (acc_q),
    .opb_i (opb_i),
    .cin_i (cin_w),
    .sub_i (is_sub_w),
    .sum_o (sum_w),
    .cy_o  (cy_w),
    .ac_o  (ac_w),
    .ov_o  (ov_w)
  );

  // switchable data pointers
  ccr_pointer_bank u_ptrs (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .sel_i      (xaux_q[`CCR_XAUX_SEL]),
    .wr_lo_i    (wr_i && addr_i == `CCR_ADDR_DPL),
    .wr_hi_i    (wr_i && addr_i == `CCR_ADDR_DPH),
    .wdata_i    (wdata_i),
    .ptr_o      (ptr_w)
  );

  // RULE5 odd count of ones sets parity
  assign parity_w = ^acc_q;

  // RULE17 config value by boot state and variant
  // low nibble kept at four bits so the concatenation stays eight wide
  assign cfg_w = {(BIG_VARIANT != 0) ? `CCR_CFG_TOP_BIG : `CCR_CFG_TOP_SML,
                  boot_q, 1'b0, cfg_low_q[3:0]};

  // next status word
  always @* begin
    psw_d = psw_q;
    case (flag_op_i)
      // RULE7 add class updates three flags
      `CCR_OP_ADD, `CCR_OP_ADDC, `CCR_OP_SUBB: begin
        psw_d[`CCR_PSW_CY] = cy_w;
        psw_d[`CCR_PSW_AC] = ac_w;
        psw_d[`CCR_PSW_OV] = ov_w;
      end
      // RULE7 multiply/divide clears carry
      `CCR_OP_MULDIV: begin
        psw_d[`CCR_PSW_CY] = 1'b0;
        psw_d[`CCR_PSW_OV] = md_ov_i;
      end
      // RULE8 carry-only operations
      `CCR_OP_CYONLY: begin
        psw_d[`CCR_PSW_CY] = cy_value_i;
      end
      // RULE8 forced carry
      `CCR_OP_SETC: begin
        psw_d[`CCR_PSW_CY] = 1'b1;
      end
      `CCR_OP_CLRC: begin
        psw_d[`CCR_PSW_CY] = 1'b0;
      end
      default: begin
        psw_d = psw_q;
      end
    endcase
    // RULE23 explicit write wins
    if (wr_i && addr_i == `CCR_ADDR_PSW)
      psw_d = wdata_i;
    // RULE6 user flags untouched by hardware paths above
    psw_d[`CCR_PSW_P] = 1'b0;
  end

  // arithmetic, status and aux registers
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_q <= `CCR_RST_ZERO;
      aux_q <= `CCR_RST_ZERO;
      psw_q <= `CCR_RST_ZERO;
    end else begin
      psw_q <= psw_d;
      // RULE9 accumulator write paths
      if (wr_i && addr_i == `CCR_ADDR_ACC)
        acc_q <= wdata_i;
      else if (acc_wr_i)
        acc_q <= acc_wdata_i;
      else if (flag_op_i == `CCR_OP_ADD || flag_op_i == `CCR_OP_ADDC ||
               flag_op_i == `CCR_OP_SUBB)
        acc_q <= sum_w;
      // RULE10 aux register write
      if (wr_i && addr_i == `CCR_ADDR_AUX)
        aux_q <= wdata_i;
    end
  end

  // stack pointer
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // RULE15 reset so first push hits 08h
      sp_q <= `CCR_RST_SP;
    end else if (wr_i && addr_i == `CCR_ADDR_SP) begin
      sp_q <= wdata_i;
    end else if (push_i) begin
      // RULE13 increment before store
      sp_q <= sp_q + 8'h01;
    end else if (pop_i) begin
      // RULE14 decrement after read
      sp_q <= sp_q - 8'h01;
    end
  end

  // power control and external bus aux
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // RULE20 power-on value
      pwr_q  <= `CCR_RST_PWR;
      xaux_q <= `CCR_RST_ZERO;
    end else begin
      if (wr_i && addr_i == `CCR_ADDR_PWR)
        pwr_q <= wdata_i;
      if (wr_i && addr_i == `CCR_ADDR_XAUX)
        xaux_q <= wdata_i;
    end
  end

  // unlock sequence and timed window
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // RULE19 unlock resets to zero
      unlock_q   <= `CCR_RST_ZERO;
      st_q       <= ST_IDLE;
      safe_cnt_q <= 5'h00;
    end else begin
      if (wr_i && addr_i == `CCR_ADDR_ID)
        unlock_q <= wdata_i;
      case (st_q)
        // RULE21 first code
        ST_IDLE: begin
          if (wr_i && addr_i == `CCR_ADDR_ID && wdata_i == `CCR_UNLOCK_A)
            st_q <= ST_HALF;
        end
        // RULE21 second code opens window
        ST_HALF: begin
          if (wr_i && addr_i == `CCR_ADDR_ID) begin
            if (wdata_i == `CCR_UNLOCK_B) begin
              st_q       <= ST_OPEN;
              safe_cnt_q <= SAFE_CYC[4:0];
            end else if (wdata_i != `CCR_UNLOCK_A) begin
              st_q <= ST_IDLE;
            end
          end
        end
        // RULE21 expiry or any write to the identity address closes
        ST_OPEN: begin
          if ((wr_i && addr_i == `CCR_ADDR_ID) || safe_cnt_q == 5'h01) begin
            st_q       <= ST_IDLE;
            safe_cnt_q <= 5'h00;
          end else begin
            safe_cnt_q <= safe_cnt_q - 5'h01;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // config register: low bits only in protected window
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // RULE22 set at power-on
      boot_q    <= 1'b1;
      cfg_low_q <= 4'h0;
      swr_q     <= 1'b0;
    end else begin
      swr_q <= 1'b0;
      if (wr_i && addr_i == `CCR_ADDR_CFG && st_q == ST_OPEN) begin
        cfg_low_q <= wdata_i[3:0];
        if (wdata_i[`CCR_CFG_SWRST]) begin
          // RULE22 soft reset clears boot state
          boot_q <= 1'b0;
          swr_q  <= 1'b1;
        end
      end
    end
  end

  // read data mux
  always @* begin
    rdata_d = 8'h00;
    case (addr_i)
      `CCR_ADDR_ACC:  rdata_d = acc_q;
      `CCR_ADDR_AUX:  rdata_d = aux_q;
      `CCR_ADDR_PSW:  rdata_d = {psw_q[7:1], parity_w};
      `CCR_ADDR_SP:   rdata_d = sp_q;
      // RULE12 pointer bytes
      `CCR_ADDR_DPL:  rdata_d = ptr_w[7:0];
      `CCR_ADDR_DPH:  rdata_d = ptr_w[15:8];
      `CCR_ADDR_PWR:  rdata_d = pwr_q;
      // RULE18 fixed identity on read
      `CCR_ADDR_ID:   rdata_d = (BIG_VARIANT != 0) ? ID_BIG : ID_SMALL;
      `CCR_ADDR_XAUX: rdata_d = xaux_q;
      `CCR_ADDR_CFG:  rdata_d = cfg_w;
      default:        rdata_d = 8'h00;
    endcase
  end

  // registered outputs
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o      <= 8'h00;
      acc_o        <= `CCR_RST_ZERO;
      psw_o        <= `CCR_RST_ZERO;
      sp_o         <= `CCR_RST_SP;
      data_pointer_word_o       <= `CCR_RST_PTR;
      bank_base_o  <= 5'h00;
      stack_addr_o <= `CCR_RST_SP;
      safe_open_o  <= 1'b0;
      sw_reset_o   <= 1'b0;
    end else begin
      rdata_o      <= rd_i ? rdata_d : 8'h00;
      acc_o        <= acc_q;
      psw_o        <= {psw_q[7:1], parity_w};
      sp_o         <= sp_q;
      data_pointer_word_o       <= ptr_w;
      // RULE1 bank base address, RULE16 RAM unaffected
      bank_base_o  <= {psw_q[`CCR_PSW_RS1], psw_q[`CCR_PSW_RS0], 3'b000};
      // RULE13 store address is incremented pointer
      stack_addr_o <= push_i ? sp_q + 8'h01 : sp_q;
      safe_open_o  <= (st_q == ST_OPEN);
      sw_reset_o   <= swr_q;
    end
  end

endmodule
`default_nettype wire

// [testbench/ccr_core_regs_sva.sv]
// assertion checker for the core register block
`timescale 1ns/1ps
`default_nettype none

module ccr_core_regs_sva #(
  parameter       BIG_VARIANT = 1,     // device variant
  parameter [7:0] ID_BIG      = 8'hC5, // arbitrary identity value
  parameter [7:0] ID_SMALL    = 8'hC4  // arbitrary identity value
) (
  // clock and reset
  input wire logic       core_clk_i,
  input wire logic       reset_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // core requests
  input wire logic [3:0] flag_op_i,
  input wire logic       push_i,
  input wire logic       pop_i,
  // views
  input wire logic [7:0] acc_o,
  input wire logic [7:0] psw_o,
  input wire logic [7:0] sp_o,
  input wire logic [4:0] bank_base_o,
  input wire logic [7:0] stack_addr_o
);
  // single domain, async reset
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // identity code of this variant
  localparam logic [7:0] ID = BIG_VARIANT ? ID_BIG : ID_SMALL;

  property p_acc_rd; rd_i && addr_i == 8'hE0 |=> rdata_o == acc_o; endproperty
  a_acc_rd: assert property (p_acc_rd) else $error("accumulator read wrong");
  property p_id_rd; rd_i && addr_i == 8'hA1 |=> rdata_o == ID; endproperty
  a_id_rd: assert property (p_id_rd) else $error("identity read wrong");
  property p_sp_rst; $rose(reset_n_i) |-> sp_o == 8'h07 && stack_addr_o == 8'h07; endproperty
  a_sp_rst: assert property (p_sp_rst) else $error("stack reset wrong");
  property p_par; psw_o[0] == ^acc_o; endproperty
  a_par: assert property (p_par) else $error("parity bit wrong");
  property p_bank; bank_base_o == {psw_o[4:3], 3'b000}; endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");
  property p_push; push_i |=> stack_addr_o == sp_o + 8'h01; endproperty
  a_push: assert property (p_push) else $error("push address wrong");
  property p_pop;
    pop_i ##1 !(push_i || pop_i || wr_i) |=> sp_o == $past(sp_o) - 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop decrement wrong");
  property p_cy_op;
    (flag_op_i == 4'h6 || flag_op_i == 4'h7) && !(wr_i && addr_i == 8'hD0)
      |-> ##2 psw_o[7] == ($past(flag_op_i, 2) == 4'h6);
  endproperty
  a_cy_op: assert property (p_cy_op) else $error("carry set or clear wrong");
  property p_psw_wr;
    wr_i && addr_i == 8'hD0 |-> ##2 ((psw_o ^ $past(wdata_i, 2)) & 8'hFE) == 8'h00;
  endproperty
  a_psw_wr: assert property (p_psw_wr) else $error("status write lost");
endmodule

bind ccr_core_regs ccr_core_regs_sva #(
  .BIG_VARIANT(BIG_VARIANT), .ID_BIG(ID_BIG), .ID_SMALL(ID_SMALL)
) u_sva (
  .core_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .flag_op_i,
  .push_i, .pop_i, .acc_o, .psw_o, .sp_o, .bank_base_o, .stack_addr_o
);
`default_nettype wire

// [testbench/tb_cpu_core_registers.sv]
// self-checking bench for the core register block
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_core_registers;
  // design inputs
  logic        core_clk_i   = 1'b0;
  logic        reset_n_i    = 1'b0;
  logic [7:0]  addr_i       = 8'h00;
  logic [7:0]  wdata_i      = 8'h00;
  logic        wr_i         = 1'b0;
  logic        rd_i         = 1'b0;
  logic [3:0]  flag_op_i    = 4'h0;
  logic [7:0]  opb_i        = 8'h00;
  logic        cy_value_i   = 1'b0;
  logic        md_ov_i      = 1'b0;
  logic        acc_wr_i     = 1'b0;
  logic [7:0]  acc_wdata_i  = 8'h00;
  logic        push_i       = 1'b0;
  logic        pop_i        = 1'b0;
  // design outputs
  wire  [7:0]  rdata_o, acc_o, psw_o, sp_o, stack_addr_o;
  wire  [15:0] data_pointer_word_o;
  wire  [4:0]  bank_base_o;
  wire         safe_open_o, sw_reset_o;
  // counters and model state
  int          num_errors   = 0;
  int          total_checks = 0;
  int          seed         = 37747;
  int          cyc, nsw, i, op, a, b, c, s, h, v, m_acc, m_psw;
  // reset table: address and expected value
  logic [7:0]  ra [10] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'hA1, 8'hB1, 8'hD0, 8'hE0, 8'hF0, 8'h90};
  int          rv [10] = '{8'h07, 0, 0, 8'h10, 8'hC5, 8'hA0, 0, 0, 0, 0};

  // design under test
  ccr_core_regs DUT (
    .core_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .flag_op_i,
    .opb_i, .cy_value_i, .md_ov_i, .acc_wr_i, .acc_wdata_i, .push_i, .pop_i, .acc_o,
    .psw_o, .sp_o, .data_pointer_word_o, .bank_base_o, .stack_addr_o, .safe_open_o, .sw_reset_o
  );

  // 40 MHz clock
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // cycle ceiling and soft reset pulse count
  always @(posedge core_clk_i) begin
    cyc++;
    if (sw_reset_o === 1'b1) nsw++;
    if (cyc == 8000) begin
      num_errors++;
      results();
    end
  end

  // compare and count
  task automatic chk(input logic [15:0] seen, input int exp, input string nm);
    total_checks++;
    if (seen !== exp[15:0]) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp[15:0], seen);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= ad;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] ad, input int exp, input string nm);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= ad;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp, nm);
  endtask

  // push or pop pulse, then stack address check
  task automatic stk(input logic up, input int exp);
    @(posedge core_clk_i);
    push_i <= up;
    pop_i <= !up;
    @(posedge core_clk_i);
    push_i <= 1'b0;
    pop_i <= 1'b0;
    #1 chk(stack_addr_o, exp, "stack address");
  endtask

  // two-step unlock
  task automatic unlock;
    wr(8'hA1, 8'h55);
    wr(8'hA1, 8'hAA);
  endtask

  // odd count of ones
  function automatic int par(input int x);
    return ^x[7:0];
  endfunction

  // verdict and end of run
  task automatic results;
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    for (i = 0; i < 10; i++) rd(ra[i], rv[i], "reset value");
    // first push, then wrap both ways
    stk(1'b1, 8'h08);
    wr(8'h81, 8'hFE);
    stk(1'b1, 8'hFF);
    stk(1'b1, 8'h00);
    stk(1'b0, 8'h00);
    rd(8'h81, 8'hFF, "stack pointer");
    // two pointers behind one window
    wr(8'hA2, 8'h00);
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    repeat (2) @(posedge core_clk_i);
    #1 chk(data_pointer_word_o, 16'h1234, "pointer word");
    wr(8'hA2, 8'h01);
    rd(8'h82, 0, "second pointer low");
    wr(8'h83, 8'hEE);
    wr(8'hA2, 8'h00);
    rd(8'h83, 8'h12, "first pointer high");
    // random write and read back
    for (i = 0; i < 16; i++) begin
      a = $random(seed) & 8'hFF;
      wr(8'hF0, a[7:0]);
      rd(8'hF0, a, "aux register");
      wr(8'hA1, a[7:0]);
      rd(8'hA1, 8'hC5, "identity");
      m_acc = a ^ 8'h5A;
      wr(8'hE0, m_acc[7:0]);
      rd(8'hE0, m_acc, "accumulator");
      wr(8'hD0, a[7:0]);
      m_psw = a & 8'hFE;
      rd(8'hD0, m_psw | par(m_acc), "status");
      chk(bank_base_o, a & 8'h18, "bank base");
    end
    // core write of the accumulator
    @(posedge core_clk_i);
    acc_wr_i <= 1'b1;
    acc_wdata_i <= 8'h3C;
    @(posedge core_clk_i);
    acc_wr_i <= 1'b0;
    m_acc = 8'h3C;
    // every flag op, random operand and carry in
    for (i = 0; i < 35; i++) begin
      op = 1 + i % 7;
      b = $random(seed) & 8'hFF;
      c = $random(seed) & 3;
      wr(8'hD0, c[0] ? 8'h80 : 8'h00);
      @(posedge core_clk_i);
      flag_op_i <= op[3:0];
      opb_i <= b[7:0];
      cy_value_i <= c[1];
      md_ov_i <= c[1];
      @(posedge core_clk_i);
      flag_op_i <= 4'h0;
      a = m_acc;
      if (op < 4) begin
        h = (op > 1) ? c[0] : 0;
        s = (op == 3) ? a - b - h : a + b + h;
        v = ((op == 3 ? a ^ b : ~(a ^ b)) & (a ^ s) & 128) != 0;
        h = (op == 3) ? ((a & 15) < (b & 15) + h) : ((a & 15) + (b & 15) + h > 15);
        m_psw = {s[8], h[0], 3'b000, v[0], 2'b00};
        m_acc = s & 8'hFF;
      end else if (op == 4) m_psw = {5'b00000, c[1], 2'b00};
      else if (op == 5) m_psw = {c[1], 7'b0000000};
      else m_psw = {op == 6, 7'b0000000};
      rd(8'hD0, m_psw | par(m_acc), "flags");
      rd(8'hE0, m_acc, "result");
    end
    // explicit status write beside a set-carry
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= 8'hD0;
    wdata_i <= 8'h22;
    flag_op_i <= 4'h6;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    flag_op_i <= 4'h0;
    rd(8'hD0, 8'h22 | par(m_acc), "status precedence");
    // protected writes: locked, cut short, expired, soft reset
    wr(8'hB1, 8'h10);
    rd(8'hB1, 8'hA0, "config locked");
    unlock();
    wr(8'hA1, 8'h00);
    wr(8'hB1, 8'h10);
    rd(8'hB1, 8'hA0, "config closed early");
    unlock();
    repeat (2) @(posedge core_clk_i);
    #1 chk(safe_open_o, 1, "window open");
    repeat (30) @(posedge core_clk_i);
    #1 chk(safe_open_o, 0, "window expired");
    unlock();
    wr(8'hB1, 8'h10);
    repeat (4) @(posedge core_clk_i);
    rd(8'hB1, 8'h80, "config after soft reset");
    chk(nsw, 1, "soft reset pulses");
    results();
  end
endmodule
`default_nettype wire
